// [hw/arf_pkg.sv]
// Purpose: Constants for the ADC parallel read-out and result queue
// Assumes: 20 MHz hclk, AHB-Lite register access
// Notes on behaviour
// - Nap when nap pin or nap bit set
// - Deep power-down only by bit, then recovery
// - Mode lines latched at combined strobe fall
// - Codes 000-101 read one channel, tag ignored
// - Code 110 cycles all six channels
// - Cycle starts at first channel after reset
// - Code 111 reads earliest result first
// - Queue holds eighteen results shared by all channels
// - Full queue drops oldest on new result
// - Results stored only after read strobe ends
// - Write lowest free entry; reset clears queue
// - Head read completes, entries shift down
// - Direct: one word, or low then high byte
// - Tag word 800h filler, valid, channel, then data
// - Byte tag: tag nibble, low byte, high byte
// - Empty queue presents sixteen zeros
// - Channel tag codes 000 to 101
// - Nap, tag and mode: pin ORed with bit
// - Invert bit gives two's complement output
package arf_pkg;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h04;
  localparam int          NAP_BIT      = 6;
  localparam int          PWRDN_BIT    = 5;
  localparam int          INV_BIT      = 4;
  localparam int          TAG_BIT      = 3;
  localparam logic [6:0]  CTRL_RST     = 7'h00;
  localparam int          ST_RDY_BIT   = 2;
  localparam int          ST_RR_LSB    = 4;
  localparam int          ST_CNT_LSB   = 8;
  localparam logic [2:0]  MODE_CYCLE   = 3'h6;
  localparam logic [2:0]  MODE_FIFO    = 3'h7;
  localparam logic [2:0]  LAST_CH      = 3'h5;
  localparam int          NUM_CH       = 6;
  localparam int          PER_CH       = 3;
  localparam logic [11:0] TAG_FILL     = 12'h800;
  localparam logic [7:0]  SYNC_RST     = 8'h03;
  localparam int          CLK_NS       = 50;
  localparam int          PWRDN_RECOV_NS  = 1000;
  localparam int          PWRDN_RECOV_CYC = (PWRDN_RECOV_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [0:0] {ARF_IDLE = 1'b0, ARF_READ = 1'b1} arf_state_e;
endpackage : arf_pkg

// [hw/arf_readout.sv]
// Purpose: Parallel read-out port with direct, cycle and queue modes
// Assumes: Results arrive on hclk as single-cycle strobes
// Notes: Pins pass two flip-flops before use
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module arf_readout #(
  parameter int DEPTH = arf_pkg::NUM_CH * arf_pkg::PER_CH,
  parameter int RECOV = arf_pkg::PWRDN_RECOV_CYC
) (
  // Bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Conversion results
  input  wire logic        result_valid,
  input  wire logic [2:0]  result_chan,
  input  wire logic [15:0] result_data,
  // Host pins
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        mode_select_bit2,
  input  wire logic        mode_select_bit1,
  input  wire logic        mode_select_bit0,
  input  wire logic        nap_pin,
  input  wire logic        tag_en_pin,
  input  wire logic        byte_mode_pin,
  output logic      [15:0] data_out,
  output logic             data_oe,
  // Power state
  output logic             nap_active,
  output logic             powerdown_active,
  output logic             conv_ready
);
  localparam int CW       = $clog2(DEPTH + 1);
  localparam int NUM_CH_L = arf_pkg::NUM_CH;

  logic [7:0]  sync1_r, sync2_r;
  logic [6:0]  ctrl_r;
  logic        wr_pend_r, rd_sel_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  arf_pkg::arf_state_e state_r;
  logic [1:0]  step_r;
  logic [2:0]  mode_lat_r;
  logic        tag_lat_r, byte_lat_r;
  logic [15:0] dout_r;
  logic [2:0]  rr_r;
  logic [15:0] last_r [NUM_CH_L];
  logic [15:0] in_r   [NUM_CH_L];
  logic [5:0]  commit_r, qpend_r, unread_r;
  logic [2:0]  fch_r  [DEPTH];
  logic [15:0] fd_r   [DEPTH];
  logic [2:0]  fch_nxt [DEPTH];
  logic [15:0] fd_nxt  [DEPTH];
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic        powerdown_prev_r;
  logic [15:0] recov_r;

  // Pin synchronisers: {byte, tag, nap, mode[2:0], rd_n, cs_n}
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= arf_pkg::SYNC_RST;
      sync2_r <= arf_pkg::SYNC_RST;
    end
    else
    begin
      sync1_r <= {byte_mode_pin, tag_en_pin, nap_pin, mode_select_bit2,
                  mode_select_bit1, mode_select_bit0, rd_n, cs_n};
      sync2_r <= sync1_r;
    end
  end

  wire       strobe   = ~sync2_r[0] & ~sync2_r[1];
  wire [2:0] mode_eff = sync2_r[4:2] | ctrl_r[2:0];
  wire       nap_eff  = sync2_r[5] | ctrl_r[arf_pkg::NAP_BIT];
  wire       tag_eff  = sync2_r[6] | ctrl_r[arf_pkg::TAG_BIT];
  wire       byte_eff = sync2_r[7];
  wire       powerdown_req = ctrl_r[arf_pkg::PWRDN_BIT];
  wire       start    = strobe && state_r == arf_pkg::ARF_IDLE;
  wire       finish   = !strobe && state_r == arf_pkg::ARF_READ;

  // Current read configuration: live at start, latched afterwards
  wire [2:0] cur_mode = start ? mode_eff : mode_lat_r;
  wire       cur_tag  = (step_r == 2'd0 && start) ? tag_eff : tag_lat_r;
  wire       cur_byte = (step_r == 2'd0 && start) ? byte_eff : byte_lat_r;
  wire       tag_use  = cur_tag && cur_mode[2:1] == 2'b11;
  wire [1:0] nsteps   = 2'd1 + {1'b0, tag_use} + {1'b0, cur_byte};
  wire [1:0] phase    = step_r + {1'b0, ~tag_use};
  wire       last_step = step_r == nsteps - 2'd1;
  wire       is_fifo  = cur_mode == arf_pkg::MODE_FIFO;
  wire       is_cycle = cur_mode == arf_pkg::MODE_CYCLE;

  // Source of the presented word
  wire [2:0]  sel_ch = is_fifo ? fch_r[0] : (is_cycle ? rr_r : cur_mode);
  wire [15:0] raw_d  = is_fifo ? fd_r[0] : last_r[sel_ch];
  wire [15:0] sel_d  = raw_d ^ {ctrl_r[arf_pkg::INV_BIT], 15'h0000};
  wire        sel_vld = is_fifo ? (cnt_r != '0) : unread_r[sel_ch];
  wire        empty_q = is_fifo && cnt_r == '0;

  function automatic logic [15:0] arf_word(input logic [1:0] ph, input logic bm,
                                           input logic vb, input logic [2:0] ch,
                                           input logic [15:0] d);
    logic [7:0] b;
    b = (ph == 2'd0) ? {vb, ch, d[3:0]} : (ph == 2'd1) ? d[7:0] : d[15:8];
    arf_word = bm ? {b, b} : ((ph == 2'd0) ? {arf_pkg::TAG_FILL, vb, ch} : d);
  endfunction : arf_word

  wire [15:0] word = empty_q ? 16'h0000 : arf_word(phase, cur_byte, sel_vld, sel_ch, sel_d);

  // Read strobe sequencing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r    <= arf_pkg::ARF_IDLE;
      step_r     <= 2'd0;
      mode_lat_r <= 3'h0;
      tag_lat_r  <= 1'b0;
      byte_lat_r <= 1'b0;
      dout_r     <= 16'h0000;
      rr_r       <= 3'h0;
    end
    else
    begin
      case (state_r)
        arf_pkg::ARF_IDLE:
        begin
          if (start)
          begin
            state_r    <= arf_pkg::ARF_READ;
            mode_lat_r <= mode_eff;
            dout_r     <= word;
            if (step_r == 2'd0)
            begin
              tag_lat_r  <= tag_eff;
              byte_lat_r <= byte_eff;
            end
          end
        end
        arf_pkg::ARF_READ:
        begin
          if (finish)
          begin
            state_r <= arf_pkg::ARF_IDLE;
            step_r  <= last_step ? 2'd0 : step_r + 2'd1;
            if (last_step && is_cycle)
              rr_r <= (rr_r == arf_pkg::LAST_CH) ? 3'h0 : rr_r + 3'h1;
          end
        end
        default: state_r <= arf_pkg::ARF_IDLE;
      endcase
    end
  end

  // Result capture, deferred while a read is in progress
  wire       pop     = finish && last_step && is_fifo && cnt_r != '0;
  wire       push    = !strobe && state_r == arf_pkg::ARF_IDLE && qpend_r != 6'h00;
  wire [2:0] push_ch = qpend_r[0] ? 3'd0 : qpend_r[1] ? 3'd1 : qpend_r[2] ? 3'd2 :
                       qpend_r[3] ? 3'd3 : qpend_r[4] ? 3'd4 : 3'd5;
  wire       drop    = push && !pop && cnt_r == CW'(DEPTH);
  wire       rr_done = finish && last_step && is_cycle;

  for (genvar c = 0; c < NUM_CH_L; c++)
  begin : g_ch
    wire hit = result_valid && result_chan == 3'(c);
    wire idle = !strobe && state_r == arf_pkg::ARF_IDLE;
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        in_r[c]     <= 16'h0000;
        last_r[c]   <= 16'h0000;
        commit_r[c] <= 1'b0;
        qpend_r[c]  <= 1'b0;
        unread_r[c] <= 1'b0;
      end
      else
      begin
        if (hit)
          in_r[c] <= result_data;
        if (idle && commit_r[c])
          last_r[c] <= in_r[c];
        commit_r[c] <= hit | (commit_r[c] & ~idle);
        qpend_r[c]  <= hit | (qpend_r[c] & ~(push && push_ch == 3'(c)));
        unread_r[c] <= (idle && commit_r[c]) | (unread_r[c] & ~(rr_done && rr_r == 3'(c)));
      end
    end
  end

  // Queue next state: shift on pop or drop, then append
  always_comb
  begin
    logic [CW-1:0] n;
    n = cnt_r;
    fch_nxt = fch_r;
    fd_nxt  = fd_r;
    if (pop || drop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        fch_nxt[i] = fch_r[i + 1];
        fd_nxt[i]  = fd_r[i + 1];
      end
      n = n - CW'(1);
    end
    if (push)
    begin
      fch_nxt[n] = push_ch;
      fd_nxt[n]  = in_r[push_ch];
      n = n + CW'(1);
    end
    cnt_nxt = n;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        fch_r[i] <= 3'h0;
        fd_r[i]  <= 16'h0000;
      end
    end
    else
    begin
      cnt_r <= cnt_nxt;
      fch_r <= fch_nxt;
      fd_r  <= fd_nxt;
    end
  end

  // Power state and recovery after deep power-down
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      powerdown_prev_r <= 1'b0;
      recov_r          <= 16'h0000;
    end
    else
    begin
      powerdown_prev_r <= powerdown_req;
      if (powerdown_prev_r && !powerdown_req)
        recov_r <= 16'(RECOV);
      else if (recov_r != 16'h0000)
        recov_r <= recov_r - 16'h0001;
    end
  end

  // AHB-Lite register slave, zero wait states
  wire        addr_ok = hsel && hready && htrans[1];
  wire [31:0] stat_w  = {16'h0000, 3'h0, 5'(cnt_r), 1'b0, rr_r, 1'b0, conv_ready,
                         powerdown_active, nap_active};
  wire [31:0] rd_w    = (haddr[7:0] == arf_pkg::CTRL_OFS) ? {25'h0, ctrl_r} :
                        (haddr[7:0] == arf_pkg::STAT_OFS) ? stat_w : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r        <= 1'b0;
      wr_addr_r        <= 8'h00;
      hrdata_r         <= 32'h0;
      ctrl_r           <= arf_pkg::CTRL_RST;
      nap_active       <= 1'b0;
      powerdown_active <= 1'b0;
      conv_ready       <= 1'b0;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata_r <= rd_w;
      if (wr_pend_r && wr_addr_r == arf_pkg::CTRL_OFS)
        ctrl_r <= hwdata[6:0];
      nap_active       <= nap_eff;
      powerdown_active <= powerdown_req;
      // Kept low in the cycle before the recovery count loads
      conv_ready       <= !powerdown_req && !powerdown_prev_r && !nap_eff && recov_r == 16'h0000;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign data_out  = dout_r;
  assign data_oe   = state_r == arf_pkg::ARF_READ;

  chk_nap_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    nap_eff |=> nap_active) else $error("nap not entered");
  chk_powerdown_recovery: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(powerdown_req) |-> ##1 !conv_ready [*3]) else $error("no recovery after power-down");
  chk_mode_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    start |=> mode_lat_r == $past(mode_eff)) else $error("mode not latched");
  chk_cycle_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    rr_done && rr_r == 3'h5 |=> rr_r == 3'h0) else $error("cycle did not wrap");
  chk_full_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    drop |=> cnt_r == CW'(DEPTH) && fch_r[DEPTH-1] == $past(push_ch)) else $error("drop failed");
  chk_read_defer: assert property (@(posedge hclk) disable iff (!hresetn)
    strobe |-> !push && cnt_nxt <= cnt_r) else $error("store during read");
  chk_pop_shift: assert property (@(posedge hclk) disable iff (!hresetn)
    pop && !push |=> cnt_r == $past(cnt_r) - CW'(1) && fd_r[0] == $past(fd_r[1]))
    else $error("head not removed");
  chk_empty_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    start && mode_eff == 3'h7 && cnt_r == '0 |=> dout_r == 16'h0000) else $error("empty not zero");
  chk_tag_fill: assert property (@(posedge hclk) disable iff (!hresetn)
    start && step_r == 2'd0 && tag_eff && mode_eff == arf_pkg::MODE_FIFO && !byte_eff && cnt_r != '0
    |=> dout_r[15:4] == 12'h800 && dout_r[3]) else $error("tag word wrong");
endmodule : arf_readout

// [sim/arf_host_model.sv]
// Purpose: Host side reader driving chip select, read strobe and mode lines
// Assumes: One read per go pulse, strobe held 4+hold edges
// Notes: Mode lines flip to the inverse four edges after the strobe is up again
`timescale 1ns/100ps
module arf_host_model (
  // Clock
  input  wire logic        hclk,
  // Bench request
  input  wire logic        go,
  input  wire logic [2:0]  mode,
  input  wire logic [3:0]  hold,
  // Device pins
  input  wire logic [15:0] data_out,
  output logic             cs_n,
  output logic             rd_n,
  output logic             mode_select_bit2,
  output logic             mode_select_bit1,
  output logic             mode_select_bit0,
  // Captured word
  output logic      [15:0] word,
  output logic             done
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} = 3'h0;
    word = 16'h0000;
    done = 1'b0;
  end
  always
  begin
    @(posedge hclk);
    if (go)
    begin
      {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= mode;
      @(posedge hclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (4 + hold) @(posedge hclk);
      word <= data_out;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (4) @(posedge hclk);
      {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= ~mode;
      done <= 1'b1;
      @(posedge hclk);
      done <= 1'b0;
    end
  end
endmodule : arf_host_model

// [sim/adc_parallel_readout_fifo_test.sv]
// Purpose: Self-checking bench for the read-out port against a queue model
// Assumes: 50 ns hclk, host reads through the partner model
// Notes: Recovery count shortened to 8 cycles
`timescale 1ns/100ps
module adc_parallel_readout_fifo_test;
  localparam int DEPTH = 18;
  localparam int RECOV = 8;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, mode = 3'h0, result_chan = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic result_valid = 1'b0, nap_pin = 1'b0, tag_en_pin = 1'b0, byte_mode_pin = 1'b0, go = 1'b0;
  logic [15:0] result_data = 16'h0, data_out, word, d;
  logic [3:0] hold = 4'h0;
  logic cs_n, rd_n, m2, m1, m0, data_oe, nap_active, powerdown_active, conv_ready, done;
  logic [31:0] seed = 32'hFE88B14F;
  int err_count = 0, total_checks = 0;
  int last_v[6];
  int q[$];
  assign hready = hreadyout;
  arf_readout #(.DEPTH(DEPTH), .RECOV(RECOV)) arf_readout_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result_valid(result_valid),
    .result_chan(result_chan), .result_data(result_data), .cs_n(cs_n), .rd_n(rd_n), .mode_select_bit2(m2),
    .mode_select_bit1(m1), .mode_select_bit0(m0), .nap_pin(nap_pin), .tag_en_pin(tag_en_pin),
    .byte_mode_pin(byte_mode_pin), .data_out(data_out), .data_oe(data_oe), .nap_active(nap_active),
    .powerdown_active(powerdown_active), .conv_ready(conv_ready));
  arf_host_model arf_host_model_i (.hclk(hclk), .go(go), .mode(mode), .hold(hold), .data_out(data_out),
    .cs_n(cs_n), .rd_n(rd_n), .mode_select_bit2(m2), .mode_select_bit1(m1), .mode_select_bit0(m0),
    .word(word), .done(done));
  always #25 hclk = ~hclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, seen);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic push(input int ch, input logic [31:0] v);
    @(posedge hclk);
    result_valid <= 1'b1;
    result_chan <= 3'(ch);
    result_data <= v[15:0];
    @(posedge hclk);
    result_valid <= 1'b0;
    last_v[ch] = int'(v[15:0]);
    if (q.size() == DEPTH) void'(q.pop_front());
    q.push_back((ch << 16) | int'(v[15:0]));
  endtask : push
  task automatic rdc(input logic [2:0] m, input logic [15:0] e);
    @(posedge hclk);
    go <= 1'b1;
    mode <= m;
    hold <= 4'(rnd() & 32'h3);
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (done !== 1'b1);
    check("data_out", 32'(word), 32'(e));
  endtask : rdc
  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    last_v = '{default: 0};
    q.delete();
  endtask : rst
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (60000) @(posedge hclk);
    err_count++;
    conclude();
  end
  initial
  begin
    rst();
    check("data_oe", 32'(data_oe), 32'h0);
    check("conv_ready", 32'(conv_ready), 32'h1);
    ahb(1'b1, arf_pkg::CTRL_OFS, 32'h1 << arf_pkg::INV_BIT);
    ahb(1'b0, arf_pkg::CTRL_OFS, 32'h0);
    check("ctrl", r, 32'h10);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF);
    ahb(1'b0, 8'h08, 32'h0);
    check("unmapped", r, 32'h0);
    tag_en_pin <= 1'b1;
    for (int c = 0; c < 6; c++) push(c, rnd());
    for (int c = 0; c < 6; c++) rdc(3'(c), 16'(last_v[c]) ^ 16'h8000);
    tag_en_pin <= 1'b0;
    ahb(1'b1, arf_pkg::CTRL_OFS, 32'h0);
    byte_mode_pin <= 1'b1;
    d = 16'(last_v[3]);
    rdc(3'h3, {d[7:0], d[7:0]});
    rdc(3'h3, {d[15:8], d[15:8]});
    byte_mode_pin <= 1'b0;
    $display("test direct done");
    nap_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    check("nap_active", 32'({nap_active, conv_ready}), 32'h2);
    nap_pin <= 1'b0;
    repeat (5) @(posedge hclk);
    check("nap_active", 32'(nap_active), 32'h0);
    ahb(1'b1, arf_pkg::CTRL_OFS, 32'h1 << arf_pkg::NAP_BIT);
    repeat (2) @(posedge hclk);
    check("nap_active", 32'(nap_active), 32'h1);
    ahb(1'b1, arf_pkg::CTRL_OFS, 32'h1 << arf_pkg::PWRDN_BIT);
    repeat (2) @(posedge hclk);
    check("powerdown_active", 32'(powerdown_active), 32'h1);
    ahb(1'b1, arf_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    check("conv_ready", 32'(conv_ready), 32'h0);
    repeat (RECOV + 4) @(posedge hclk);
    check("conv_ready", 32'(conv_ready), 32'h1);
    $display("test power done");
    rst();
    for (int c = 0; c < 6; c++) push(c, rnd());
    for (int i = 0; i < 7; i++) rdc(arf_pkg::MODE_CYCLE, 16'(last_v[i % 6]));
    $display("test cycle done");
    rst();
    rdc(arf_pkg::MODE_FIFO, 16'h0);
    repeat (3) push(int'(rnd() % 6), rnd());
    ahb(1'b0, arf_pkg::STAT_OFS, 32'h0);
    check("status", r, (32'h3 << arf_pkg::ST_CNT_LSB) | (32'h1 << arf_pkg::ST_RDY_BIT));
    while (q.size() > 0) rdc(arf_pkg::MODE_FIFO, 16'(q.pop_front()));
    rdc(arf_pkg::MODE_FIFO, 16'h0);
    repeat (DEPTH + 1) push(int'(rnd() % 6), rnd());
    while (q.size() > 0) rdc(arf_pkg::MODE_FIFO, 16'(q.pop_front()));
    tag_en_pin <= 1'b1;
    push(4, rnd());
    d = 16'(last_v[4]);
    rdc(arf_pkg::MODE_FIFO, {arf_pkg::TAG_FILL, 4'hC});
    rdc(arf_pkg::MODE_FIFO, d);
    byte_mode_pin <= 1'b1;
    push(5, rnd());
    d = 16'(last_v[5]);
    rdc(arf_pkg::MODE_FIFO, {2{4'hD, d[3:0]}});
    rdc(arf_pkg::MODE_FIFO, {2{d[7:0]}});
    rdc(arf_pkg::MODE_FIFO, {2{d[15:8]}});
    $display("test queue done");
    conclude();
  end
endmodule : adc_parallel_readout_fifo_test
